// >>> rtl/led_driver_control_registers.v
// Control and status registers of a three-channel LED buck driver,
// reached over the serial port, plus channel gating and bootstrap upkeep.
// Assumes the serial host runs mode 0 frames far slower than clk and
// that analog status inputs are asynchronous levels.
//
// Operation
// (RULE1) Host sets link-ready, polls before configuring
// (RULE2) Bit 7 reports serial link operating
// (RULE3) Error-clear bit self-clears after errors cleared
// (RULE4) Request with no error waits next error
// (RULE5) Host writes zero to reserved bits
// (RULE6) Dim enable zero keeps channel off
// (RULE7) Gate code sets (255-code) times 62 mV
// (RULE8) Host avoids codes outside 0x5D..0xA6
// (RULE9) Host reads gate code back after write
// (RULE10) Die temperature read as signed degrees
// (RULE11) Out-of-range temperature resolved by overtemp flag
// (RULE12) Recharge bootstrap each period when idle
// (RULE13) Charge compensation needs driver, low pin, health
// (RULE14) Enabled high dim pin lets gate switch
// (RULE15) Gate code stored unclamped as written
`timescale 1ns/100ps
`include "led_ctrl_defines.vh"
module led_driver_control_registers #(
    parameter MEAS_CYCLES     = `MEAS_CYCLES,
    parameter RECHARGE_CYCLES = `RECHARGE_CYCLES
) (
    input  wire       clk,
    input  wire       rst,
    input  wire       spi_sclk,
    input  wire       spi_cs_n,
    input  wire       spi_mosi,
    output reg        spi_miso_q,
    output reg        spi_miso_oe_q,
    input  wire       device_enable,
    input  wire       error_present,
    input  wire       dim_pin_ch1,
    input  wire       dim_pin_ch2,
    input  wire       dim_pin_ch3,
    input  wire [2:0] current_reached_raw,
    input  wire [2:0] gate_switching,
    input  wire [2:0] bootstrap_uv,
    input  wire [2:0] headroom_low,
    input  wire [7:0] temp_code,
    output reg  [2:0] gate_drive_out_q,
    output reg  [2:0] bootstrap_recharge_q,
    output reg  [2:0] charge_comp_en_q,
    output reg  [7:0] gate_supply_code_q,
    output reg        gate_code_allowed_q,
    output reg        error_clear_q
);
    // Limits cut to the 17-bit counters; both default counts fit
    localparam [16:0] MEAS_LIM = MEAS_CYCLES[16:0];
    localparam [16:0] RC_LIM   = RECHARGE_CYCLES[16:0];

    // Synchronised copies of every asynchronous input except temp_code
    wire [19:0] async_in;
    wire [19:0] sync_out;
    wire        sclk_s;
    wire        cs_n_s;
    wire        mosi_s;
    wire        enable_s;
    wire        err_s;
    wire [2:0]  dim_s;
    wire [2:0]  cr_s;
    wire [2:0]  sw_s;
    wire [2:0]  bsuv_s;
    wire [2:0]  hr_s;

    // Select enters inverted so the zero reset of the flops reads as idle,
    // otherwise a false frame start would follow every reset
    assign async_in = {headroom_low, bootstrap_uv, gate_switching,
                       current_reached_raw, dim_pin_ch3, dim_pin_ch2,
                       dim_pin_ch1, error_present, device_enable,
                       spi_mosi, ~spi_cs_n, spi_sclk};

    sync_two_stage #(
        .W (20)
    ) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (async_in),
        .dout (sync_out)
    );

    assign sclk_s   = sync_out[0];
    assign cs_n_s   = ~sync_out[1]; // Undo the input inversion
    assign mosi_s   = sync_out[2];
    assign enable_s = sync_out[3];
    assign err_s    = sync_out[4];
    assign dim_s    = sync_out[7:5];
    assign cr_s     = sync_out[10:8];
    assign sw_s     = sync_out[13:11];
    assign bsuv_s   = sync_out[16:14];
    assign hr_s     = sync_out[19:17];

    // Register state
    reg        ready_q;
    reg        clr_req_q;
    reg [2:0]  dim_en_q;
    reg [7:0]  temp_q;

    // Serial engine state
    reg        sclk_p_q;
    reg        cs_p_q;
    reg [15:0] shift_q;
    reg [4:0]  cnt_q;
    reg [7:0]  tx_q;

    // Bootstrap timing state
    reg [16:0] low_cnt_q [0:2];
    reg [16:0] period_q;

    wire [7:0] fc_rd;
    assign fc_rd = {ready_q, clr_req_q, 2'b00, dim_en_q, 1'b0};

    // Read mux; unmapped addresses read as zero
    // Address is the seven bits that follow the write flag
    function [7:0] read_reg;
        input [6:0] a;
        begin
            case (a)
                `ADDR_FUNC_CTRL:   read_reg = fc_rd;
                `ADDR_GATE_SUPPLY: read_reg = gate_supply_code_q;
                `ADDR_DIE_TEMP:    read_reg = temp_q;
                default:           read_reg = 8'h00;
            endcase
        end
    endfunction

    // Edge detection on synchronised serial lines
    wire sclk_rise;
    wire sclk_fall;
    wire cs_fall;
    wire cs_rise;
    assign sclk_rise = sclk_s & ~sclk_p_q;
    assign sclk_fall = ~sclk_s & sclk_p_q;
    assign cs_fall   = ~cs_n_s & cs_p_q;
    assign cs_rise   = cs_n_s & ~cs_p_q;

    // A frame commits only when exactly sixteen bits arrived
    wire       wr_stb;
    wire [6:0] wr_addr;
    wire [7:0] wr_data;
    wire       wr_fc;
    wire       wr_gs;
    assign wr_stb  = cs_rise & (cnt_q == `FRAME_BITS) & shift_q[`FRAME_WR_BIT];
    assign wr_addr = shift_q[14:8];
    assign wr_data = shift_q[7:0];
    assign wr_fc   = wr_stb & (wr_addr == `ADDR_FUNC_CTRL);
    assign wr_gs   = wr_stb & (wr_addr == `ADDR_GATE_SUPPLY);

    // Serial shifter: sample on rising, drive on falling
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_p_q      <= 1'b0;
            cs_p_q        <= 1'b1;
            shift_q       <= 16'h0000;
            cnt_q         <= 5'h00;
            tx_q          <= 8'h00;
            spi_miso_q    <= 1'b0;
            spi_miso_oe_q <= 1'b0;
        end else begin
            sclk_p_q <= sclk_s;
            cs_p_q   <= cs_n_s;
            if (cs_n_s) begin
                cnt_q         <= 5'h00;
                spi_miso_oe_q <= 1'b0;
            end else if (cs_fall) begin
                // Status byte leads every answer
                cnt_q         <= 5'h00;
                spi_miso_oe_q <= 1'b1;
                spi_miso_q    <= fc_rd[7];
                tx_q          <= {fc_rd[6:0], 1'b0};
            end else begin
                if (sclk_rise) begin
                    shift_q <= {shift_q[14:0], mosi_s};
                    // Count saturates so long frames never wrap to sixteen
                    if (cnt_q != 5'h1F) begin
                        cnt_q <= cnt_q + 5'h01;
                    end
                    // Address complete: prepare read data byte
                    if (cnt_q == 5'h07) begin
                        tx_q <= read_reg({shift_q[5:0], mosi_s});
                    end
                end
                if (sclk_fall) begin
                    spi_miso_q <= tx_q[7];
                    tx_q       <= {tx_q[6:0], 1'b0};
                end
            end
        end
    end

    // Function control: ready flag and channel enables
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ready_q  <= `FC_READY_RESET;
            dim_en_q <= 3'b000;
        end else begin
            // Link not available while the device is disabled
            if (!enable_s) begin
                ready_q <= 1'b0;                                  // RULE1
            end else if (wr_fc) begin
                ready_q <= wr_data[`FC_READY_BIT];                // RULE2
            end
            // Reserved bits are dropped on write, read as zero
            if (wr_fc) begin
                dim_en_q <= {wr_data[`FC_DIM3_BIT], wr_data[`FC_DIM2_BIT],
                             wr_data[`FC_DIM1_BIT]};              // RULE5
            end
        end
    end

    // Error clear request: held until an error is seen and gone
    // Writing zero to the bit never cancels a pending request
    wire clr_set;
    wire clr_done;
    assign clr_set  = wr_fc & wr_data[`FC_CLR_BIT];
    assign clr_done = error_clear_q & ~err_s;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            clr_req_q     <= 1'b0;
            error_clear_q <= 1'b0;
        end else begin
            // A new write wins over the self-clear in the same cycle
            clr_req_q     <= clr_set | (clr_req_q & ~clr_done);   // RULE3
            error_clear_q <= clr_req_q & err_s;                   // RULE4
        end
    end

    // Gate supply code kept exactly as written
    // Out-of-window codes stay readable so the host can catch them
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            gate_supply_code_q  <= `GS_RESET;
            gate_code_allowed_q <= 1'b1;
        end else begin
            if (wr_gs) begin
                gate_supply_code_q <= wr_data;                    // RULE15
            end
            // Flag only; the regulator gets (255-code) steps of GS_STEP_MV
            gate_code_allowed_q <= (gate_supply_code_q >= `GS_CODE_MIN) &&
                                   (gate_supply_code_q <= `GS_CODE_MAX); // RULE7
        end
    end

    // Temperature passes through raw so out-of-range codes stay visible
    // The host settles such codes with the overtemp flag elsewhere
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            temp_q <= 8'h00;
        end else begin
            temp_q <= temp_code;                                  // RULE10 RULE11
        end
    end

    // Recharge period tick shared by the three channels
    // Free running from reset, so the first pulse may come early
    wire period_tick;
    assign period_tick = (period_q == RC_LIM - 17'h00001);
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            period_q <= 17'h00000;
        end else if (period_tick) begin
            period_q <= 17'h00000;
        end else begin
            period_q <= period_q + 17'h00001;
        end
    end

    // Gate driver is usable only while enabled and free of errors
    // A fail-silent error drops gates and compensation together
    wire drv_en;
    assign drv_en = enable_s & ~err_s;

    // Per-channel low-time counters, switching and bootstrap outputs
    integer i;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            for (i = 0; i < 3; i = i + 1) begin
                low_cnt_q[i] <= 17'h00000;
            end
            gate_drive_out_q     <= 3'b000;
            bootstrap_recharge_q <= 3'b000;
            charge_comp_en_q     <= 3'b000;
        end else begin
            for (i = 0; i < 3; i = i + 1) begin
                // Saturating count of continuous low time on the pin
                if (dim_s[i]) begin
                    low_cnt_q[i] <= 17'h00000;
                end else if (low_cnt_q[i] < MEAS_LIM) begin
                    low_cnt_q[i] <= low_cnt_q[i] + 17'h00001;
                end
                gate_drive_out_q[i] <= drv_en & dim_en_q[i] & dim_s[i]; // RULE6 RULE14
                bootstrap_recharge_q[i] <= period_tick & ~sw_s[i] &
                    ((low_cnt_q[i] >= MEAS_LIM) |
                     (dim_s[i] & ~cr_s[i]));                      // RULE12
                charge_comp_en_q[i] <= drv_en & ~dim_s[i] &
                    ~bsuv_s[i] & ~hr_s[i];                        // RULE13
            end
        end
    end
endmodule // led_driver_control_registers

// >>> rtl/led_ctrl_defines.vh
// Constants for the LED driver control register block.
// Included by the register block; holds definitions only.
`ifndef LED_CTRL_DEFINES_VH
`define LED_CTRL_DEFINES_VH

// Register addresses (7-bit address field of a serial frame)
`define ADDR_FUNC_CTRL      7'h00
`define ADDR_GATE_SUPPLY    7'h01
`define ADDR_DIE_TEMP       7'h26

// Function control field positions
`define FC_READY_BIT        7
`define FC_CLR_BIT          6
`define FC_DIM3_BIT         3
`define FC_DIM2_BIT         2
`define FC_DIM1_BIT         1

// Reset values; no documented values, chosen safe
`define FC_RESET            8'h00
`define GS_RESET            8'hA6
`define FC_READY_RESET      1'b0

// Permitted gate supply code window and step
`define GS_CODE_MIN         8'h5D
`define GS_CODE_MAX         8'hA6
`define GS_STEP_MV          62

// Serial frame: write flag, 7-bit address, 8-bit data
`define FRAME_BITS          5'h10
`define FRAME_WR_BIT        15

// Timing
`define CLK_MHZ             50
`define T_MEAS_US           1000
`define T_RECHARGE_US       500
`define MEAS_CYCLES         (`T_MEAS_US * `CLK_MHZ)
`define RECHARGE_CYCLES     (`T_RECHARGE_US * `CLK_MHZ)

`endif

// >>> rtl/sync_two_stage.v
// Two flip-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; no bus coherence is kept.
`timescale 1ns/100ps
module sync_two_stage #(
    parameter W = 1
) (
    clk,
    rst,
    din,
    dout
);
    input  wire         clk;
    input  wire         rst;
    input  wire [W-1:0] din;
    output reg  [W-1:0] dout;

    reg [W-1:0] meta_q;

    // First stage feeds only the second stage
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= {W{1'b0}};
            dout   <= {W{1'b0}};
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule // sync_two_stage

// >>> test/led_ctrl_monitor.sv
// Port checks for the LED control register block.
// Assumes pins pass two sync flops, so outputs trail them by three edges.
`timescale 1ns/100ps
module led_ctrl_monitor #(
    parameter MEAS_CYCLES     = 20,
    parameter RECHARGE_CYCLES = 10
) (
    input wire       clk,
    input wire       rst,
    input wire       spi_cs_n,
    input wire       spi_miso_oe_q,
    input wire       error_present,
    input wire       dim_pin_ch1,
    input wire [2:0] gate_switching,
    input wire [2:0] bootstrap_uv,
    input wire [2:0] headroom_low,
    input wire [2:0] gate_drive_out_q,
    input wire [2:0] bootstrap_recharge_q,
    input wire [2:0] charge_comp_en_q,
    input wire [7:0] gate_supply_code_q,
    input wire       gate_code_allowed_q,
    input wire       error_clear_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_gate_rise: assert property ($rose(gate_drive_out_q[0]) |-> $past(dim_pin_ch1, 3))
        else $error("gate rose without dim pin");
    a_err_off: assert property (error_present [*4] |-> !gate_drive_out_q && !charge_comp_en_q)
        else $error("channel active during error");
    a_comp_rise: assert property ($rose(charge_comp_en_q[0]) |-> !$past(dim_pin_ch1, 3)
        && !$past(bootstrap_uv[0], 3) && !$past(headroom_low[0], 3))
        else $error("compensation rose with bad condition");
    a_rch_pulse: assert property (bootstrap_recharge_q[0] |=> !bootstrap_recharge_q[0])
        else $error("recharge pulse too long");
    a_rch_idle: assert property (bootstrap_recharge_q[2] |-> !$past(gate_switching[2], 3))
        else $error("recharge while switching");
    a_code_ok: assert property (gate_code_allowed_q == ($past(gate_supply_code_q) >= 8'h5D
        && $past(gate_supply_code_q) <= 8'hA6)) else $error("allowed flag wrong");
    a_code_hold: assert property (spi_cs_n [*6] |-> $stable(gate_supply_code_q))
        else $error("gate code moved outside frame");
    a_oe_frame: assert property ($fell(spi_cs_n) |-> ##[2:5] spi_miso_oe_q)
        else $error("miso not driven in frame");
    a_oe_idle: assert property (spi_cs_n [*5] |-> !spi_miso_oe_q)
        else $error("miso driven while idle");
    a_clear_cause: assert property (error_clear_q |-> $past(error_present, 3))
        else $error("clear without error");
endmodule // led_ctrl_monitor

bind led_driver_control_registers led_ctrl_monitor #(
    .MEAS_CYCLES(MEAS_CYCLES), .RECHARGE_CYCLES(RECHARGE_CYCLES)
) i_mon (
    .clk(clk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_miso_oe_q(spi_miso_oe_q),
    .error_present(error_present), .dim_pin_ch1(dim_pin_ch1), .gate_switching(gate_switching),
    .bootstrap_uv(bootstrap_uv), .headroom_low(headroom_low),
    .gate_drive_out_q(gate_drive_out_q), .bootstrap_recharge_q(bootstrap_recharge_q),
    .charge_comp_en_q(charge_comp_en_q), .gate_supply_code_q(gate_supply_code_q),
    .gate_code_allowed_q(gate_code_allowed_q), .error_clear_q(error_clear_q)
);

// >>> test/spi_host_model.sv
// Serial host model: mode 0 frames of 16 bits, 160 ns clock.
// Assumes calls start on a falling clk edge; delays keep that phase.
`timescale 1ns/100ps
module spi_host_model (
    output reg  sclk,
    output reg  cs_n,
    output reg  mosi,
    input  wire miso,
    input  wire miso_oe
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // Bit taken just before sclk falls, where the device output has settled
    task xfer(input [15:0] tx, output [15:0] rx);
        integer i;
        begin
            cs_n = 1'b0;
            #160;
            for (i = 15; i >= 0; i = i - 1) begin
                mosi = tx[i];
                #80 sclk = 1'b1;
                #80 rx[i] = miso_oe ? miso : ~miso; // Undriven line never reads as data
                sclk = 1'b0;
            end
            #80 cs_n = 1'b1;
            mosi = ~mosi; // Released line shows no stale value
            #160;
        end
    endtask
endmodule // spi_host_model

// >>> test/led_driver_control_registers_tb.sv
// Testbench for the LED control register block.
// Assumes the host model and the bound port monitor.
`timescale 1ns/100ps
module led_driver_control_registers_tb;
    reg        clk = 1'b0, rst = 1'b1, device_enable = 1'b0, error_present = 1'b0;
    reg        dim_pin_ch1 = 1'b0, dim_pin_ch2 = 1'b0, dim_pin_ch3 = 1'b0;
    reg  [2:0] cr = 3'h0, gsw = 3'h0, buv = 3'h0, hl = 3'h0;
    reg  [7:0] temp_code = 8'h00, c, p0, p2;
    reg [15:0] rx;
    integer    i, n, n_errors = 0, total_checks = 0;
    wire       sclk, cs_n, mosi, miso, oe;
    wire [2:0] gate, rch, comp;
    wire [7:0] code;
    wire       ok, clr;

    spi_host_model i_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(oe));
    led_driver_control_registers #(.MEAS_CYCLES(20), .RECHARGE_CYCLES(10)) i_dut (
        .clk(clk), .rst(rst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
        .spi_miso_q(miso), .spi_miso_oe_q(oe), .device_enable(device_enable),
        .error_present(error_present), .dim_pin_ch1(dim_pin_ch1), .dim_pin_ch2(dim_pin_ch2),
        .dim_pin_ch3(dim_pin_ch3), .current_reached_raw(cr), .gate_switching(gsw),
        .bootstrap_uv(buv), .headroom_low(hl), .temp_code(temp_code),
        .gate_drive_out_q(gate), .bootstrap_recharge_q(rch), .charge_comp_en_q(comp),
        .gate_supply_code_q(code), .gate_code_allowed_q(ok), .error_clear_q(clr));

    // Free running 50 MHz clock
    always #10 clk = ~clk;

    task chk(input [15:0] got, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [6:0] a, input [7:0] d);
        i_host.xfer({1'b1, a, d}, rx);
    endtask
    task rd(input [6:0] a);
        i_host.xfer({1'b0, a, 8'h00}, rx);
    endtask
    task settle;
        repeat (6) @(negedge clk);
    endtask

    task t_ready;
        begin
            rd(7'h01);
            chk(rx, 16'h00A6);
            device_enable = 1'b1;
            wr(7'h00, 8'h80);
            rd(7'h00);
            chk(rx, 16'h8080);
            device_enable = 1'b0;
            settle;
            rd(7'h00);
            chk(rx, 16'h0000);
            device_enable = 1'b1;
            wr(7'h00, 8'h80);
            rd(7'h00);
            chk(rx, 16'h8080);
            $display("test ready done");
        end
    endtask

    // Both window ends and two inner codes; the host never leaves the window
    task t_gate;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                c = 32'h5DA680A5 >> (24 - 8 * i);
                wr(7'h01, c);
                rd(7'h01);
                chk(rx, {8'h80, c});
                chk({8'h0, code}, {8'h0, c});
                chk({15'h0, ok}, {15'h0, c >= 8'h5D && c <= 8'hA6});
            end
            $display("test gate done");
        end
    endtask

    task t_temp;
        begin
            for (i = 0; i < 3; i = i + 1) begin
                temp_code = 24'hD8FFAF >> (16 - 8 * i);
                wr(7'h26, 8'h00);
                rd(7'h26);
                chk(rx, {8'h80, temp_code});
            end
            $display("test temp done");
        end
    endtask

    task t_dim;
        begin
            wr(7'h00, 8'h84);
            {dim_pin_ch3, dim_pin_ch2, dim_pin_ch1} = 3'h7;
            settle;
            chk({13'h0, gate}, 16'h0002);
            wr(7'h00, 8'h8E);
            settle;
            chk({13'h0, gate}, 16'h0007);
            {dim_pin_ch3, dim_pin_ch2, dim_pin_ch1} = 3'h0;
            settle;
            chk({13'h0, gate}, 16'h0000);
            $display("test dim done");
        end
    endtask

    task t_clear;
        begin
            wr(7'h00, 8'hCE);
            rd(7'h00);
            chk(rx, 16'hCECE);
            error_present = 1'b1;
            n = 0;
            while (clr !== 1'b1 && n < 20) begin
                @(negedge clk);
                n = n + 1;
            end
            chk({15'h0, clr}, 16'h0001);
            error_present = 1'b0;
            settle;
            rd(7'h00);
            chk({15'h0, clr}, 16'h0000);
            chk(rx, 16'h8E8E);
            $display("test clear done");
        end
    endtask

    // Counts recharge pulses on ch1 and ch3 over six periods
    task count;
        begin
            settle;
            p0 = 8'h00;
            p2 = 8'h00;
            for (i = 0; i < 60; i = i + 1) begin
                @(negedge clk);
                p0 = p0 + {7'h0, rch[0]};
                p2 = p2 + {7'h0, rch[2]};
            end
        end
    endtask
    task t_boot;
        begin
            gsw = 3'h4;
            buv = 3'h1;
            settle;
            chk({13'h0, comp}, 16'h0006);
            hl = 3'h2;
            count;
            chk({13'h0, comp}, 16'h0004);
            chk({8'h0, p0}, 16'h0006);
            chk({8'h0, p2}, 16'h0000);
            dim_pin_ch1 = 1'b1;
            cr = 3'h1;
            count;
            chk({8'h0, p0}, 16'h0000);
            cr = 3'h0;
            count;
            chk({8'h0, p0}, 16'h0006);
            $display("test boot done");
        end
    endtask

    task close_out;
        begin
            $display("checks=%0d errors=%0d", total_checks, n_errors);
            if (n_errors == 0 && total_checks > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask

    // Main sequence
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        settle;
        t_ready;
        t_gate;
        t_temp;
        t_dim;
        t_clear;
        t_boot;
        close_out;
    end

    // Watchdog, roughly six times the expected run
    initial begin
        #500000;
        n_errors = n_errors + 1;
        close_out;
    end
endmodule // led_driver_control_registers_tb
